// >>> slcu_defs.svh
// Constants for the level one command unit.
`ifndef SLCU_DEFS_SVH
`define SLCU_DEFS_SVH
`define SLCU_CMD_RESET      8'h00
`define SLCU_CMD_ABORT      8'h01
`define SLCU_CMD_ATN        8'h02
`define SLCU_CMD_NACK       8'h03
`define SLCU_CMD_DISC       8'h04
`define SLCU_CMD_SET_IDI    8'h0F
`define SLCU_CMD_SET_PHASE  8'h28
`define SLCU_ST_RESET       8'h00
`define SLCU_ST_RESET_ADV   8'h01
`define SLCU_ST_SUCCESS     8'h11
`define SLCU_ST_PAUSED      8'h21
`define SLCU_ST_PROTO       8'h25
`define SLCU_ST_UNEXP_PHASE 8'h48
`define SLCU_ST_BUS_FREE    8'h85
`define SLCU_ST_SEL_GLITCH  8'h41
`define SLCU_ST_DISC_IDI    8'h85
`define SLCU_MC_REV         8'h5A
`define SLCU_SEL_ABORT_US   200
`define SLCU_CLK_MHZ        10
`define SLCU_SEL_ABORT_CYC  (`SLCU_SEL_ABORT_US * `SLCU_CLK_MHZ)
`define SLCU_CYC_W          12
`define SLCU_BLK_W          12
`define SLCU_PH_MSG         2
`define SLCU_PH_CD          1
`define SLCU_PH_IO          0
`endif

// >>> slcu_pkg.sv
// Types for the level one command unit.
package slcu_pkg;
    typedef enum logic [1:0] {SLCU_DISC, SLCU_INIT, SLCU_TARG, SLCU_SCAM} slcu_state_e;
    typedef struct packed {
        logic msg;
        logic cd;
        logic io;
    } slcu_phase_s;
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } slcu_irq_s;
endpackage : slcu_pkg

// >>> slcu_sync.sv
// Two-stage synchroniser for bus-side levels.
`timescale 1ns/1ps
module slcu_sync #(parameter int W = 1) (
    input  wire logic         mclk,    // Device clock.
    input  wire logic         resetn,  // Asynchronous reset, active low.
    input  wire logic [W-1:0] d,       // Asynchronous levels.
    output logic      [W-1:0] q        // Synchronised levels.
);
    logic [W-1:0] meta_q;
    // Stage one feeds stage two only.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : slcu_sync

// >>> slcu_tgt_model.sv
// Behavioural bus target that answers a selection with busy.
`timescale 1ns/1ps
module slcu_tgt_model (
    input  wire logic        mclk,        // Device clock.
    input  wire logic        sel_in,      // Select from the device.
    input  wire logic [11:0] answer_dly,  // Cycles until busy, zero never answers.
    output logic             bsy_out      // Busy, deasserted when released.
);
    int cnt = 0;
    // busy answer: raises busy after the chosen delay, drops it with select.
    always @(posedge mclk) begin
        cnt = sel_in ? cnt + 1 : 0;
        bsy_out <= sel_in && answer_dly != 12'h000 && cnt >= int'(answer_dly);
    end
endmodule : slcu_tgt_model

// >>> slcu_unit.sv
// Level one command unit of the bus interface controller.
`timescale 1ns/1ps
`include "slcu_defs.svh"
module slcu_unit (
    input  wire logic                 mclk,             // Device clock, 10 MHz.
    input  wire logic                 resetn,           // Master reset, active low.
    input  wire logic                 cmd_valid,        // Command write strobe.
    input  wire logic [7:0]           cmd_code,         // Command code.
    input  wire logic                 own_adv_en,       // Own-identity advanced bit.
    input  wire logic                 own_radv_en,      // Own-identity really advanced bit.
    input  wire logic [2:0]           own_bus_id,       // Own-identity bus id.
    input  wire logic [7:0]           ctrl_bus_reg,     // Control bus register value.
    input  wire logic                 dir_expect_in,    // Expected data direction bit.
    input  wire logic                 dir_check_off,    // Direction check disable bit.
    input  wire logic                 l2_busy,          // Level two command running.
    input  wire logic                 l2_is_sat,        // Running command is select-and-transfer.
    input  wire logic                 l2_is_send,       // Running command is a send.
    input  wire logic                 l2_is_recv,       // Running command is a receive.
    input  wire logic                 arb_won,          // Arbitration has been won.
    input  wire logic                 sat_data_phase,   // Select-and-transfer data phase start.
    input  wire logic                 sat_tgt_gone,     // Target has disconnected.
    input  wire logic                 byte_moved,       // One byte moved on the bus.
    input  wire logic                 fifo_empty,       // Internal FIFO drained.
    input  wire logic                 proto_err,        // Handshake corruption seen.
    input  wire logic                 last_msg_out,     // Last message-out byte next.
    input  wire logic                 ident_sent,       // Identify byte sent in select-and-transfer.
    input  wire logic                 ack_hold_evt,     // Interrupt cause that keeps ack.
    input  wire logic                 ack_auto_evt,     // Initiator byte done, ack may drop.
    input  wire logic                 tgt_disc_evt,     // Current target disconnected.
    input  wire logic                 bus_io_pin,       // Bus I/O line, asynchronous.
    input  wire logic                 bus_bsy_pin,      // Bus busy line, asynchronous.
    input  wire logic                 bus_sel_pin,      // Bus select line, asynchronous.
    input  wire logic                 bus_atn_pin,      // Bus attention line, asynchronous.
    input  wire logic                 bus_par_err_pin,  // Bus parity fault, asynchronous.
    input  wire logic                 stop_on_bus_parity_fault, // Halt on parity enable.
    output slcu_pkg::slcu_state_e     state_q,          // Connection state.
    output slcu_pkg::slcu_irq_s       irq_q,            // One-cycle interrupt with status.
    output logic                      adv_q,            // Advanced features active.
    output logic                      radv_q,           // Really advanced features active.
    output logic [7:0]                first_command_byte_reg, // First command byte register.
    output logic [2:0]                bus_id_q,         // Own bus id in use.
    output logic                      l2_kill_q,        // Pulse ending a level two command.
    output logic                      host_data_request,// Data request to host.
    output logic                      sel_out_q,        // Drive select.
    output logic                      ids_out_q,        // Drive bus id bits.
    output logic                      atn_out_q,        // Drive attention.
    output logic                      ack_out_q,        // Drive acknowledge.
    output slcu_pkg::slcu_phase_s     phase_out_q,      // Driven phase lines.
    output logic                      intermediate_disconnect_irq, // Intermediate arm flag.
    output logic                      tgt_aborted_q     // Target abort stopped a transfer.
);
    import slcu_pkg::*;

    // ************************************************************
    // Synchronised bus inputs
    // ************************************************************
    logic [4:0] pins_s;
    slcu_sync #(.W(5)) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      ({bus_io_pin, bus_bsy_pin, bus_sel_pin, bus_atn_pin, bus_par_err_pin}),
        .q      (pins_s)
    );
    logic io_s, bsy_s, sel_s, atn_s, par_s;
    assign {io_s, bsy_s, sel_s, atn_s, par_s} = pins_s;

    // Decodes whether a level one command is valid in a state.
    function automatic logic cmd_ok(input logic [7:0] c, input slcu_state_e s);
        logic r;
        r = 1'b0;
        unique case (c)
            `SLCU_CMD_RESET:     r = 1'b1;
            `SLCU_CMD_ABORT:     r = (s == SLCU_DISC) || (s == SLCU_TARG);
            `SLCU_CMD_ATN:       r = (s == SLCU_INIT);
            `SLCU_CMD_NACK:      r = (s == SLCU_INIT);
            `SLCU_CMD_DISC:      r = (s != SLCU_DISC);
            `SLCU_CMD_SET_IDI:   r = (s != SLCU_SCAM);
            `SLCU_CMD_SET_PHASE: r = (s == SLCU_SCAM);
            default:             r = 1'b0;
        endcase
        return r;
    endfunction : cmd_ok

    logic is_cmd;
    assign is_cmd = cmd_valid && cmd_ok(cmd_code, state_q);
    logic do_reset, do_abort, do_disc;
    assign do_reset = is_cmd && (cmd_code == `SLCU_CMD_RESET);
    assign do_abort = is_cmd && (cmd_code == `SLCU_CMD_ABORT);
    assign do_disc  = is_cmd && (cmd_code == `SLCU_CMD_DISC);
    // A running send or receive implies a target connection; selection aborts exclude it.
    logic tgt_xfer, sel_abort;
    assign tgt_xfer  = (state_q == SLCU_TARG) || (l2_busy && (l2_is_send || l2_is_recv));
    assign sel_abort = do_abort && state_q == SLCU_DISC && l2_busy && !l2_is_sat && !tgt_xfer;

    // ************************************************************
    // Abort sequencer
    // ************************************************************
    typedef enum logic [2:0] {AB_IDLE, AB_SELWAIT, AB_DRAIN_TX, AB_DRAIN_RX} slcu_ab_e;
    slcu_ab_e ab_q;
    logic [`SLCU_CYC_W-1:0] sel_cnt_q;
    logic [`SLCU_BLK_W-1:0] blk_cnt_q;
    logic internal_abort;
    logic blk_edge;
    assign blk_edge = byte_moved && (blk_cnt_q == `SLCU_BLK_W'(4095));
    assign internal_abort = tgt_xfer && l2_busy && l2_is_recv && (ab_q == AB_IDLE)
        && (radv_q ? ((par_s && stop_on_bus_parity_fault) || atn_s)
                   : (blk_edge && ((par_s && stop_on_bus_parity_fault) || atn_s)));

    // Byte counter marking 4096-byte boundaries.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            blk_cnt_q <= '0;
        end else if (!l2_busy) begin
            blk_cnt_q <= '0;
        end else if (byte_moved) begin
            blk_cnt_q <= blk_cnt_q + `SLCU_BLK_W'(1);
        end
    end

    // Abort state machine and select timeout.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ab_q      <= AB_IDLE;
            sel_cnt_q <= '0;
        end else if (do_reset || do_disc) begin
            ab_q <= AB_IDLE;
        end else begin
            unique case (ab_q)
                AB_IDLE: begin
                    if (sel_abort && arb_won) begin
                        ab_q      <= AB_SELWAIT;
                        sel_cnt_q <= '0;
                    end else if ((do_abort || proto_err) && tgt_xfer && l2_is_send) begin
                        ab_q <= AB_DRAIN_TX;
                    end else if ((do_abort || proto_err || internal_abort)
                                 && tgt_xfer && l2_is_recv) begin
                        ab_q <= AB_DRAIN_RX;
                    end
                end
                AB_SELWAIT: begin
                    sel_cnt_q <= sel_cnt_q + `SLCU_CYC_W'(1);
                    if (bsy_s || sel_cnt_q == `SLCU_CYC_W'(`SLCU_SEL_ABORT_CYC - 1)) begin
                        ab_q <= AB_IDLE;
                    end
                end
                AB_DRAIN_TX, AB_DRAIN_RX: begin
                    if (fifo_empty) begin
                        ab_q <= AB_IDLE;
                    end
                end
                default: ab_q <= AB_IDLE;
            endcase
        end
    end

    // Pending protocol-error status for the drain completion.
    logic proto_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            proto_q <= 1'b0;
        end else if (ab_q == AB_IDLE && proto_err && tgt_xfer) begin
            proto_q <= 1'b1;
        end else if (ab_q == AB_IDLE) begin
            proto_q <= 1'b0;
        end
    end

    // ************************************************************
    // Connection state and feature enables
    // ************************************************************
    logic sel_glitch;
    assign sel_glitch = (state_q == SLCU_INIT) && l2_busy && !bsy_s && !sel_s && tgt_disc_evt;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SLCU_DISC;
        end else if (do_reset || do_disc || sel_glitch) begin
            state_q <= SLCU_DISC;
        end else if (do_abort && l2_is_sat && sat_tgt_gone) begin
            state_q <= SLCU_DISC;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            adv_q                  <= 1'b0;
            radv_q                 <= 1'b0;
            bus_id_q               <= '0;
            first_command_byte_reg <= '0;
        end else if (do_reset) begin
            adv_q    <= own_adv_en;
            radv_q   <= own_radv_en;
            bus_id_q <= own_bus_id;
            if (own_radv_en) begin
                first_command_byte_reg <= `SLCU_MC_REV;
            end
        end
    end

    // ************************************************************
    // Interrupt generation
    // ************************************************************
    logic dir_bad;
    assign dir_bad = adv_q && !dir_check_off && l2_is_sat && sat_data_phase
                     && (dir_expect_in != io_s);

    // One-cycle interrupt, highest priority first.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= '0;
        end else begin
            irq_q <= '0;
            if (do_reset) begin
                irq_q <= '{1'b1, own_adv_en ? `SLCU_ST_RESET_ADV : `SLCU_ST_RESET};
            end else if (sel_abort && !arb_won) begin
                irq_q <= '{1'b1, `SLCU_ST_PAUSED};
            end else if (do_abort && l2_is_sat && sat_tgt_gone) begin
                irq_q <= '{1'b1, `SLCU_ST_BUS_FREE};
            end else if (ab_q == AB_SELWAIT && bsy_s) begin
                irq_q <= '{1'b1, `SLCU_ST_SUCCESS};
            end else if (ab_q == AB_SELWAIT
                         && sel_cnt_q == `SLCU_CYC_W'(`SLCU_SEL_ABORT_CYC - 1)) begin
                irq_q <= '{1'b1, `SLCU_ST_PAUSED};
            end else if ((ab_q == AB_DRAIN_TX || ab_q == AB_DRAIN_RX) && fifo_empty) begin
                irq_q <= '{1'b1, proto_q ? `SLCU_ST_PROTO : `SLCU_ST_PAUSED};
            end else if (sel_glitch) begin
                irq_q <= '{1'b1, l2_is_sat ? `SLCU_ST_BUS_FREE : `SLCU_ST_SEL_GLITCH};
            end else if (dir_bad) begin
                irq_q <= '{1'b1, `SLCU_ST_UNEXP_PHASE};
            end else if (tgt_disc_evt && intermediate_disconnect_irq) begin
                irq_q <= '{1'b1, `SLCU_ST_DISC_IDI};
            end
        end
    end

    // ************************************************************
    // Bus line drivers
    // ************************************************************
    // id removal
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel_out_q <= 1'b0;
            ids_out_q <= 1'b0;
        end else if (do_reset || do_disc) begin
            sel_out_q <= 1'b0;
            ids_out_q <= 1'b0;
        end else if (ab_q == AB_IDLE && sel_abort && arb_won) begin
            sel_out_q <= 1'b1;
            ids_out_q <= 1'b0;
        end else if (ab_q == AB_SELWAIT && (bsy_s
                     || sel_cnt_q == `SLCU_CYC_W'(`SLCU_SEL_ABORT_CYC - 1))) begin
            sel_out_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            atn_out_q <= 1'b0;
        end else if (do_reset || do_disc || last_msg_out || ident_sent || !bsy_s) begin
            atn_out_q <= 1'b0;
        end else if (is_cmd && cmd_code == `SLCU_CMD_ATN) begin
            atn_out_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_out_q <= 1'b0;
        end else if (ack_hold_evt) begin
            ack_out_q <= 1'b1;
        end else if (do_reset || do_disc || ack_auto_evt
                     || (is_cmd && cmd_code == `SLCU_CMD_NACK)) begin
            ack_out_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_out_q <= '0;
        end else if (do_reset || do_disc) begin
            phase_out_q <= '0;
        end else if (is_cmd && cmd_code == `SLCU_CMD_SET_PHASE) begin
            phase_out_q <= '{ctrl_bus_reg[`SLCU_PH_MSG], ctrl_bus_reg[`SLCU_PH_CD],
                             ctrl_bus_reg[`SLCU_PH_IO]};
        end
    end

    // arm flag; a disconnect event in the same cycle still sees the arm.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            intermediate_disconnect_irq <= 1'b0;
        end else if (is_cmd && cmd_code == `SLCU_CMD_SET_IDI) begin
            intermediate_disconnect_irq <= 1'b1;
        end else if (do_reset || tgt_disc_evt) begin
            intermediate_disconnect_irq <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            l2_kill_q     <= 1'b0;
            tgt_aborted_q <= 1'b0;
        end else begin
            l2_kill_q <= do_reset || (do_disc && state_q != SLCU_SCAM)
                         || ((ab_q == AB_DRAIN_TX || ab_q == AB_DRAIN_RX) && fifo_empty)
                         || (do_abort && l2_is_sat && sat_tgt_gone);
            if ((ab_q == AB_DRAIN_TX || ab_q == AB_DRAIN_RX) && fifo_empty) begin
                tgt_aborted_q <= 1'b1;
            end else if (cmd_valid || do_reset) begin
                tgt_aborted_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            host_data_request <= 1'b0;
        end else begin
            host_data_request <= l2_busy && (ab_q != AB_DRAIN_TX) && !(do_abort && l2_is_send)
                                 && !fifo_empty;
        end
    end
endmodule : slcu_unit

// >>> slcu_unit_sva.sv
// Assertion checker for the level one command unit.
`timescale 1ns/1ps
`include "slcu_defs.svh"
module slcu_unit_sva (
    input wire logic                  mclk,                        // Device clock.
    input wire logic                  resetn,                      // Reset, active low.
    input wire logic                  cmd_valid,                   // Command strobe.
    input wire logic [7:0]            cmd_code,                    // Command code.
    input wire logic                  own_adv_en,                  // Advanced bit.
    input wire logic                  own_radv_en,                 // Really advanced bit.
    input wire logic                  l2_busy,                     // Level two running.
    input wire logic                  l2_is_sat,                   // Select-and-transfer.
    input wire logic                  arb_won,                     // Arbitration won.
    input wire logic                  sat_tgt_gone,                // Target gone.
    input wire logic                  bus_bsy_pin,                 // Bus busy line.
    input wire slcu_pkg::slcu_state_e state_q,                     // Connection state.
    input wire slcu_pkg::slcu_irq_s   irq_q,                       // Interrupt pulse.
    input wire logic                  adv_q,                       // Advanced active.
    input wire logic                  radv_q,                      // Really advanced active.
    input wire logic [7:0]            first_command_byte_reg,      // First command byte.
    input wire logic                  sel_out_q,                   // Select driven.
    input wire logic                  ids_out_q,                   // Id bits driven.
    input wire logic                  intermediate_disconnect_irq  // Disconnect arm flag.
);
    import slcu_pkg::*;
    logic [11:0] sel_cnt_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Counts how long select waits unanswered, so the busy wait stays bounded.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) sel_cnt_q <= 12'h000;
        else sel_cnt_q <= (sel_out_q && !bus_bsy_pin) ? sel_cnt_q + 12'h001 : 12'h000;
    end
    sequence rst_cmd_s;
        cmd_valid && cmd_code == `SLCU_CMD_RESET;
    endsequence
    sequence abort_s;
        cmd_valid && cmd_code == `SLCU_CMD_ABORT && state_q == SLCU_DISC && l2_busy;
    endsequence
    rst_status_a: assert property (rst_cmd_s |=> irq_q.valid && irq_q.code ==
        ($past(own_adv_en) ? `SLCU_ST_RESET_ADV : `SLCU_ST_RESET)) else $error("reset status wrong");
    rst_load_a: assert property (rst_cmd_s |=> adv_q == $past(own_adv_en) &&
        radv_q == $past(own_radv_en) && state_q == SLCU_DISC) else $error("reset load wrong");
    rev_load_a: assert property (rst_cmd_s ##0 own_radv_en |=>
        first_command_byte_reg == `SLCU_MC_REV) else $error("revision not loaded");
    hw_off_a: assert property ($rose(resetn) |-> !adv_q && !radv_q)
        else $error("features on after reset");
    early_abort_a: assert property (abort_s ##0 (!arb_won && !l2_is_sat) |=>
        irq_q.valid && irq_q.code == `SLCU_ST_PAUSED) else $error("early abort wrong");
    sel_hold_a: assert property (abort_s ##0 (arb_won && !l2_is_sat) |=>
        sel_out_q && !ids_out_q) else $error("select abort drive wrong");
    bsy_ok_a: assert property ($rose(bus_bsy_pin) && sel_out_q |-> ##[1:5]
        (irq_q.valid && irq_q.code == `SLCU_ST_SUCCESS)) else $error("busy answer missed");
    sel_wait_a: assert property (sel_cnt_q <= 12'h7DA) else $error("select wait too long");
    sat_gone_a: assert property (abort_s ##0 (l2_is_sat && sat_tgt_gone && !arb_won) |->
        ##[1:3] (irq_q.valid && irq_q.code == `SLCU_ST_BUS_FREE)) else $error("sat abort wrong");
    idi_arm_a: assert property (cmd_valid && cmd_code == `SLCU_CMD_SET_IDI &&
        state_q != SLCU_SCAM |=> intermediate_disconnect_irq) else $error("arm not set");
    quiet_cmd_a: assert property (cmd_valid && state_q == SLCU_DISC && !l2_busy &&
        cmd_code inside {8'h02, 8'h03, 8'h04, 8'h28} |=> (!irq_q.valid)[*3])
        else $error("ignored command interrupted");
endmodule : slcu_unit_sva
bind slcu_unit slcu_unit_sva chk_u (.*);

// >>> slcu_unit_tb_top.sv
// Self-checking bench for the level one command unit.
`timescale 1ns/1ps
`include "slcu_defs.svh"
module slcu_unit_tb_top;
    import slcu_pkg::*;
    logic        mclk, resetn, cmd_valid, own_adv_en, own_radv_en, dir_expect_in, dir_check_off;
    logic        l2_busy, l2_is_sat, l2_is_send, l2_is_recv, arb_won, sat_data_phase;
    logic        sat_tgt_gone, byte_moved, fifo_empty, proto_err, last_msg_out, ident_sent;
    logic        ack_hold_evt, ack_auto_evt, tgt_disc_evt, bus_io_pin, bus_bsy_pin, bus_sel_pin;
    logic        bus_atn_pin, bus_par_err_pin, stop_on_bus_parity_fault, adv_q, radv_q;
    logic        host_data_request, sel_out_q, ids_out_q, atn_out_q, ack_out_q, l2_kill_q;
    logic        intermediate_disconnect_irq, tgt_aborted_q;
    logic [7:0]  cmd_code, ctrl_bus_reg, first_command_byte_reg;
    logic [2:0]  own_bus_id, bus_id_q;
    logic [11:0] answer_dly;
    logic [31:0] r;
    slcu_state_e state_q;
    slcu_irq_s   irq_q;
    slcu_phase_s phase_out_q;
    logic [7:0]  exp_q[$];
    int          fail_count, n_tests, cyc, seed;
    slcu_unit dut_u (.*);
    slcu_tgt_model tgt_u (.mclk(mclk), .sel_in(sel_out_q), .answer_dly(answer_dly),
        .bsy_out(bus_bsy_pin));
    // ************ Helpers ************
    // Compares one value and counts the result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Issues one command as a single-cycle strobe.
    task automatic cmd(input logic [7:0] code);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge mclk);
        cmd_valid <= 1'b0;
    endtask : cmd
    // Waits, bounded, until every noted interrupt has been seen.
    task automatic wait_q;
        for (int i = 0; i < 2500 && exp_q.size() != 0; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
    endtask : wait_q
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // Makes the 10 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Compares each interrupt with the oldest note; an unnoted one is a mismatch.
    always @(posedge mclk) begin
        if (resetn === 1'b1 && irq_q.valid === 1'b1) begin
            if (exp_q.size() == 0) chk(irq_q.code, 8'hFF);
            else chk(irq_q.code, exp_q.pop_front());
        end
    end
    // Cuts a hang short and drives background inputs from the seeded source.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 12000) begin
            fail_count++;
            stop_test;
        end
        r = $random(seed);
        {dir_expect_in, dir_check_off, bus_io_pin, bus_atn_pin, last_msg_out} <= r[4:0];
        {ident_sent, ack_auto_evt, byte_moved, ack_hold_evt, stop_on_bus_parity_fault} <= r[9:5];
        ctrl_bus_reg <= r[17:10];
    end
    // ************ Main sequence ************
    initial begin
        seed = 31578;
        resetn = 1'b0;
        {cmd_valid, own_adv_en, own_radv_en, l2_busy, l2_is_sat, l2_is_send, l2_is_recv} = '0;
        {arb_won, sat_data_phase, sat_tgt_gone, fifo_empty, proto_err, tgt_disc_evt} = '0;
        {bus_sel_pin, bus_par_err_pin, cmd_code, own_bus_id, answer_dly} = '0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(8'({adv_q, radv_q}), 8'h00);
        for (int i = 0; i < 4; i++) begin
            own_adv_en  <= i[0];
            own_radv_en <= i[1];
            own_bus_id  <= 3'($random(seed));
            exp_q.push_back(i[0] ? `SLCU_ST_RESET_ADV : `SLCU_ST_RESET);
            cmd(`SLCU_CMD_RESET);
            wait_q;
            chk(8'({adv_q, radv_q, bus_id_q}), 8'({i[0], i[1], own_bus_id}));
            if (i[1]) chk(first_command_byte_reg, `SLCU_MC_REV);
        end
        for (int k = 0; k < 4; k++) begin
            cmd(8'({8'h02, 8'h03, 8'h04, 8'h28} >> (8 * (3 - k))));
            repeat (3) @(posedge mclk);
            chk(8'({atn_out_q, phase_out_q}), 8'h00);
        end
        l2_busy <= 1'b1;
        exp_q.push_back(`SLCU_ST_PAUSED);
        cmd(`SLCU_CMD_ABORT);
        wait_q;
        {arb_won, answer_dly} <= {1'b1, 12'h005};
        exp_q.push_back(`SLCU_ST_SUCCESS);
        cmd(`SLCU_CMD_ABORT);
        wait_q;
        answer_dly <= 12'h000;
        exp_q.push_back(`SLCU_ST_PAUSED);
        cmd(`SLCU_CMD_ABORT);
        repeat (2000) @(posedge mclk);
        chk(8'(sel_out_q), 8'h01);
        wait_q;
        chk(8'(sel_out_q), 8'h00);
        exp_q.push_back(`SLCU_ST_RESET_ADV);
        cmd(`SLCU_CMD_ABORT);
        repeat (100) @(posedge mclk);
        cmd(`SLCU_CMD_RESET);
        wait_q;
        chk(8'(sel_out_q), 8'h00);
        {arb_won, l2_busy, l2_is_sat} <= 3'b011;
        cmd(`SLCU_CMD_ABORT);
        repeat (5) @(posedge mclk);
        sat_tgt_gone <= 1'b1;
        exp_q.push_back(`SLCU_ST_BUS_FREE);
        cmd(`SLCU_CMD_ABORT);
        wait_q;
        {l2_is_sat, sat_tgt_gone, l2_is_send} <= 3'b001;
        proto_err <= 1'b1;
        @(posedge mclk);
        proto_err <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(8'(host_data_request), 8'h00);
        exp_q.push_back(`SLCU_ST_PROTO);
        fifo_empty <= 1'b1;
        wait_q;
        chk(8'(tgt_aborted_q), 8'h01);
        {l2_busy, l2_is_send} <= 2'b00;
        cmd(`SLCU_CMD_SET_IDI);
        repeat (2) @(posedge mclk);
        chk(8'(intermediate_disconnect_irq), 8'h01);
        exp_q.push_back(`SLCU_ST_DISC_IDI);
        tgt_disc_evt <= 1'b1;
        @(posedge mclk);
        tgt_disc_evt <= 1'b0;
        wait_q;
        chk(8'(intermediate_disconnect_irq), 8'h00);
        chk(8'(exp_q.size()), 8'h00);
        stop_test;
    end
endmodule : slcu_unit_tb_top
